/* File: debug_ext_pkg.sv */
// constants, register map and bus carriers for the external debug interface
// assumes one clock domain; the register port follows the APB v3 protocol
package debug_ext_pkg;

  localparam int DATA_W = 32;
  localparam int ADDR_W = 10;
  localparam int BASE_W = 20;

  // byte offsets of the memory-mapped registers
  localparam logic [11:0] OFF_ROM_ADDRESS = 12'h008;
  localparam logic [11:0] OFF_SELF_ADDRESS = 12'h00C;
  localparam logic [11:0] OFF_CACHE_CONTROL = 12'h028;
  localparam logic [11:0] OFF_STATUS = 12'h088;
  localparam logic [11:0] OFF_RUN_CONTROL = 12'h090;
  localparam logic [11:0] OFF_POWER_CONTROL = 12'h310;
  localparam logic [11:0] OFF_AUTH_STATUS = 12'hFB8;

  // status register fields
  localparam int ST_HALTED = 0;
  localparam int ST_RESTARTED = 1;
  localparam int ST_MOE_LO = 2;
  localparam int ST_FORCE_ACK = 10;
  localparam int ST_HALT_EN_LO = 14;
  localparam int ST_INV = 16;
  localparam int ST_NONINV = 17;

  // run control, power control and cache control fields
  localparam int RC_HALT = 0;
  localparam int RC_RESTART = 1;
  localparam int PC_KEEP_POWER = 0;
  localparam int CC_LINEFILL = 0;
  localparam int CC_WRITE_BACK = 2;

  localparam logic [3:0] MOE_HALT_CMD = 4'h0;
  localparam logic [3:0] MOE_EXT_HALT = 4'h4;

  localparam logic [2:0] CACHE_CONTROL_RST = 3'h0;
  localparam logic POWER_CONTROL_RST = 1'h0;
  localparam logic RESTARTED_RST = 1'h1;

  typedef enum logic [1:0] {RUNNING, ENTERING, HALTED, EXITING} dbg_state_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
    logic srcFlag;
  } apb_req_t;

  typedef struct packed {
    logic [DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_t;

endpackage

/* File: sync2.sv */
// two-flop level synchroniser for a bundle of pin inputs
// assumes the inputs are quasi-static levels relative to clk_sys
module sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end

endmodule

/* File: apb_debug_slave.sv */
// APB v3 slave front end: one wait state, registered read data and error
// assumes the master holds address and controls stable through the access phase
module apb_debug_slave
  import debug_ext_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input debug_ext_pkg::apb_req_t req,
  input wire logic [debug_ext_pkg::DATA_W-1:0] rdData,
  input wire logic mapped,
  output debug_ext_pkg::apb_rsp_t rsp,
  output logic wrStrobe,
  output logic fromDebugger
);

  logic ackd;
  logic errFlag;
  logic [DATA_W-1:0] rdHold;

  wire access = req.psel & req.penable;
  wire firstCycle = access & ~ackd;

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      ackd <= 1'b0;
      errFlag <= 1'b0;
      rdHold <= '0;
      fromDebugger <= 1'b0;
    end else begin
      ackd <= firstCycle;
      if (firstCycle) begin
        rdHold <= req.pwrite ? '0 : rdData;
        errFlag <= ~mapped;
        fromDebugger <= req.srcFlag;
      end
    end
  end

  // stall one cycle, then complete with data or error
  assign rsp.pready = ackd;
  assign rsp.pslverr = ackd & errFlag;
  assign rsp.prdata = rdHold;
  assign wrStrobe = ackd & req.pwrite & ~errFlag;

  property p_apb_wait;
    @(posedge clk_sys) disable iff (!rst_b)
    firstCycle |=> rsp.pready ##1 !rsp.pready;
  endproperty
  a_apb_wait: assert property (p_apb_wait)
    else $error("access phase did not complete after one wait state");

endmodule

/* File: debug_external_interface.sv */
// external debug interface: register port, halt and restart handshakes,
// authentication gating, power and cache controls seen in debug state
// assumes pins are asynchronous to clk_sys; core-side inputs are on clk_sys
//
// Behaviour
// - in debug with cache bit 2 clear, data cache hits are write-through
// - instruction cache invalidates are permitted in debug regardless of privilege
// - APB v3 slave, 32-bit data, stalls, errors, address bits 11 down to 2
// - an extra address-side flag tells which source issued each access
// - external halt request enters debug and sets method of entry to 0100
// - halt acknowledge goes high once debug state is entered
// - halt acknowledge is also high while the force-acknowledge bit is set
// - keep-power output follows bit 0 of the power control register
// - ROM base and its valid flag read back through the ROM address register
// - self-offset and its valid flag read back through the self address register
// - restart acknowledge when ready; resume only after restart request drops
// - halt accepted marks entry start; a missing acknowledge means stalled memory
// - non-invasive debug permitted when either enable is high
// - invasive enable low masks halt enables and ignores halting events
// - enables read back in status bits 17:16, 15:14 and authentication status
// - pin restart clears restarted, leaves debug, clears halted, drops ack, sets restarted; run control restart skips the first step
module debug_external_interface
  import debug_ext_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input debug_ext_pkg::apb_req_t apbReq,
  output debug_ext_pkg::apb_rsp_t apbRsp,
  input wire logic external_halt_request,
  output logic halt_acknowledge,
  output logic halt_accepted,
  input wire logic restart_request,
  output logic restart_acknowledge,
  output logic keep_power_request,
  input wire logic [debug_ext_pkg::BASE_W-1:0] rom_table_base,
  input wire logic rom_table_base_valid,
  input wire logic [debug_ext_pkg::BASE_W-1:0] self_offset,
  input wire logic self_offset_valid,
  input wire logic invasive_enable,
  input wire logic noninvasive_enable,
  input wire logic coreQuiesced,
  input wire logic corePrivileged,
  output logic haltCore,
  output logic coreInDebug,
  output logic dcacheForceWriteThrough,
  output logic dcacheLinefillInhibit,
  output logic icacheMaintPermit,
  output logic noninvasivePermitted,
  output logic accessFromDebugger
);

  import debug_ext_pkg::*;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [11:0] off);
    hit = (a == off[11:2]);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  localparam int SYNC_W = 4 + 2 * BASE_W + 2;

  logic [SYNC_W-1:0] syncOut;
  logic haltPin;
  logic restartPin;
  logic invEn;
  logic nonInvEn;
  logic [BASE_W-1:0] romBase;
  logic [BASE_W-1:0] selfOff;
  logic romValid;
  logic selfValid;

  sync2 #(.WIDTH(SYNC_W)) pinSync (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .d({external_halt_request, restart_request, invasive_enable, noninvasive_enable,
        rom_table_base, self_offset, rom_table_base_valid, self_offset_valid}),
    .q(syncOut)
  );

  assign {haltPin, restartPin, invEn, nonInvEn, romBase, selfOff, romValid, selfValid} =
    syncOut;

  ////////////////////////////////////////////////////////////////////////////
  // register port

  logic wrStrobe;
  logic [DATA_W-1:0] rdData;
  logic mapped;

  apb_debug_slave slave (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .req(apbReq),
    .rdData(rdData),
    .mapped(mapped),
    .rsp(apbRsp),
    .wrStrobe(wrStrobe),
    .fromDebugger(accessFromDebugger)
  );

  wire selRom = hit(apbReq.paddr, OFF_ROM_ADDRESS);
  wire selSelf = hit(apbReq.paddr, OFF_SELF_ADDRESS);
  wire selCache = hit(apbReq.paddr, OFF_CACHE_CONTROL);
  wire selStatus = hit(apbReq.paddr, OFF_STATUS);
  wire selRun = hit(apbReq.paddr, OFF_RUN_CONTROL);
  wire selPower = hit(apbReq.paddr, OFF_POWER_CONTROL);
  wire selAuth = hit(apbReq.paddr, OFF_AUTH_STATUS);

  assign mapped = selRom | selSelf | selCache | selStatus | selRun | selPower | selAuth;

  wire wrCache = wrStrobe & selCache;
  wire wrStatus = wrStrobe & selStatus;
  wire wrRun = wrStrobe & selRun;
  wire wrPower = wrStrobe & selPower;
  wire haltCmd = wrRun & apbReq.pwdata[RC_HALT];
  wire restartCmd = wrRun & apbReq.pwdata[RC_RESTART];

  ////////////////////////////////////////////////////////////////////////////
  // control registers

  dbg_state_t state;
  dbg_state_t next_state;
  logic [2:0] cacheControl;
  logic powerControl;
  logic forceAck;
  logic [1:0] haltEnables;
  logic [3:0] entryMethod;
  logic restartedFlag;
  logic haltPending;

  wire inDebug = (state == HALTED) || (state == EXITING);
  wire haltEvent = invEn & (haltPin | haltPending);
  wire enterNow = (state == RUNNING) && (next_state == ENTERING);
  wire leaveHalt = (state == HALTED) && (next_state != HALTED);
  wire resumeNow = inDebug && (next_state == RUNNING);

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      cacheControl <= CACHE_CONTROL_RST;
      powerControl <= POWER_CONTROL_RST;
      forceAck <= 1'b0;
      haltEnables <= 2'h0;
    end else begin
      if (wrCache) begin
        cacheControl <= apbReq.pwdata[2:0];
      end
      if (wrPower) begin
        powerControl <= apbReq.pwdata[PC_KEEP_POWER];
      end
      if (wrStatus) begin
        forceAck <= apbReq.pwdata[ST_FORCE_ACK];
        haltEnables <= apbReq.pwdata[ST_HALT_EN_LO +: 2];
      end
    end
  end

  // a halt command arriving as the pending one is consumed is kept
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      haltPending <= 1'b0;
    end else if (haltCmd) begin
      haltPending <= 1'b1;
    end else if (enterNow || !invEn) begin
      haltPending <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // halt and restart sequencing

  always_comb begin
    next_state = state;
    case (state)
      RUNNING: begin
        if (haltEvent) begin
          next_state = ENTERING;
        end
      end
      ENTERING: begin
        if (coreQuiesced) begin
          next_state = HALTED;
        end
      end
      HALTED: begin
        if (restartPin) begin
          next_state = EXITING;
        end else if (restartCmd) begin
          next_state = RUNNING;
        end
      end
      EXITING: begin
        if (!restartPin) begin
          next_state = RUNNING;
        end
      end
      default: begin
        next_state = RUNNING;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      state <= RUNNING;
      entryMethod <= MOE_HALT_CMD;
      restartedFlag <= RESTARTED_RST;
    end else begin
      state <= next_state;
      if (enterNow) begin
        entryMethod <= haltPin ? MOE_EXT_HALT : MOE_HALT_CMD;
      end
      if (resumeNow) begin
        restartedFlag <= 1'b1;
      end else if (leaveHalt) begin
        restartedFlag <= 1'b0;
      end
    end
  end

  assign halt_accepted = (state == ENTERING);
  assign halt_acknowledge = inDebug | forceAck;
  assign restart_acknowledge = (state == EXITING);
  assign haltCore = (state != RUNNING);
  assign coreInDebug = inDebug;
  assign keep_power_request = powerControl;

  ////////////////////////////////////////////////////////////////////////////
  // cache, privilege and authentication effects

  assign dcacheForceWriteThrough = inDebug & ~cacheControl[CC_WRITE_BACK];
  assign dcacheLinefillInhibit = inDebug & ~cacheControl[CC_LINEFILL];
  assign icacheMaintPermit = corePrivileged | inDebug;
  assign noninvasivePermitted = invEn | nonInvEn;

  ////////////////////////////////////////////////////////////////////////////
  // read data

  wire [1:0] effEnables = haltEnables & {2{invEn}};
  wire [DATA_W-1:0] statusWord = {14'h0000, nonInvEn, invEn, effEnables, 3'h0, forceAck,
    4'h0, entryMethod, restartedFlag, inDebug};
  wire [DATA_W-1:0] authWord = {28'h000_0000, 1'b1, noninvasivePermitted, 1'b1, invEn};
  wire [DATA_W-1:0] romWord = {romBase, 11'h000, romValid};
  wire [DATA_W-1:0] selfWord = {selfOff, 11'h000, selfValid};

  assign rdData = selStatus ? statusWord :
                  selAuth ? authWord :
                  selRom ? romWord :
                  selSelf ? selfWord :
                  selCache ? {29'h0000_0000, cacheControl} :
                  selPower ? {31'h0000_0000, powerControl} :
                  32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  property p_ext_entry;
    @(posedge clk_sys) disable iff (!rst_b)
    (state == RUNNING && invEn && haltPin) |=> halt_accepted && entryMethod == 4'h4;
  endproperty
  a_ext_entry: assert property (p_ext_entry)
    else $error("external halt did not start entry with method 0100");

  property p_ack_on_entry;
    @(posedge clk_sys) disable iff (!rst_b)
    (halt_accepted && coreQuiesced) |=> halt_acknowledge && !halt_accepted;
  endproperty
  a_ack_on_entry: assert property (p_ack_on_entry)
    else $error("halt acknowledge missing after debug entry");

  property p_force_ack;
    @(posedge clk_sys) disable iff (!rst_b)
    (wrStatus && apbReq.pwdata[10]) |=> halt_acknowledge;
  endproperty
  a_force_ack: assert property (p_force_ack)
    else $error("force acknowledge did not raise halt acknowledge");

  property p_keep_power;
    @(posedge clk_sys) disable iff (!rst_b)
    wrPower |=> keep_power_request == $past(apbReq.pwdata[0]);
  endproperty
  a_keep_power: assert property (p_keep_power)
    else $error("keep power does not follow power control bit 0");

  property p_resume;
    @(posedge clk_sys) disable iff (!rst_b)
    (restart_acknowledge && !restartPin) |=> !haltCore && restartedFlag && !restart_acknowledge;
  endproperty
  a_resume: assert property (p_resume)
    else $error("core did not resume after restart request dropped");

  property p_restart_seq;
    @(posedge clk_sys) disable iff (!rst_b)
    (state == HALTED && restartPin) |=> restart_acknowledge && !restartedFlag && haltCore;
  endproperty
  a_restart_seq: assert property (p_restart_seq)
    else $error("restart did not clear restarted flag and acknowledge");

  property p_no_halt_without_inv;
    @(posedge clk_sys) disable iff (!rst_b)
    (state == RUNNING && !invEn) |=> !halt_accepted;
  endproperty
  a_no_halt_without_inv: assert property (p_no_halt_without_inv)
    else $error("halting event taken with invasive debug disabled");

  property p_entry_no_ack;
    @(posedge clk_sys) disable iff (!rst_b)
    $rose(halt_accepted) |-> !inDebug ##1 (halt_accepted || inDebug);
  endproperty
  a_entry_no_ack: assert property (p_entry_no_ack)
    else $error("halt accepted did not lead toward debug state");

  property p_write_through;
    @(posedge clk_sys) disable iff (!rst_b)
    dcacheForceWriteThrough |-> inDebug && !cacheControl[2];
  endproperty
  a_write_through: assert property (p_write_through)
    else $error("write-through forced outside debug state");

  property p_icache_debug;
    @(posedge clk_sys) disable iff (!rst_b)
    $rose(inDebug) |-> icacheMaintPermit;
  endproperty
  a_icache_debug: assert property (p_icache_debug)
    else $error("instruction cache maintenance refused in debug state");

  property p_noninv;
    @(posedge clk_sys) disable iff (!rst_b)
    (!invEn && !nonInvEn) |-> !noninvasivePermitted;
  endproperty
  a_noninv: assert property (p_noninv)
    else $error("non-invasive debug permitted with both enables low");

endmodule

/* File: debug_host_model.sv */
// debugger-side model: drives the halt and restart request pins
// assumes commands from the bench arrive as one-cycle pulses on the falling edge
module debug_host_model (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic doHalt,
  input wire logic cancelHalt,
  input wire logic doRestart,
  input wire logic haltAck,
  input wire logic restartAck,
  input wire logic keepPower,
  output logic haltPin,
  output logic restartPin,
  output logic powerEmulated
);
  timeunit 1ns;
  timeprecision 1ps;

  // halt pin held until acknowledged; cancel only for refused halts
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      haltPin <= 1'b0;
    end else if (cancelHalt) begin
      haltPin <= 1'b0;
    end else if (doHalt) begin
      haltPin <= 1'b1;
    end else if (haltAck) begin
      haltPin <= 1'b0;
    end
  end

  // restart pin dropped once acknowledged
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      restartPin <= 1'b0;
    end else if (doRestart) begin
      restartPin <= 1'b1;
    end else if (restartAck) begin
      restartPin <= 1'b0;
    end
  end

  // power controller stays in emulation while keep-power is high
  assign powerEmulated = keepPower;
endmodule

/* File: tb.sv */
// self-checking bench for the external debug interface
// assumes the design package is compiled first; one clock, no random stimulus
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import debug_ext_pkg::*;

  localparam logic [19:0] ROM_BASE = 20'hA_5C31;
  localparam logic [19:0] SELF_OFS = 20'h0_2007;

  logic clk_sys, rst_b;
  apb_req_t req;
  apb_rsp_t rsp;
  logic haltPin, haltAck, haltAccepted, restartPin, restartAck, keepPower;
  logic invEn, noninvEn, coreQuiesced, corePrivileged;
  logic haltCore, coreInDebug, forceWt, icachePermit, nonInvPermitted, fromDbg;
  logic doHalt, cancelHalt, doRestart, powerEmulated, sawAccepted, sawRestartAck;
  logic clrSaw, lfInhibit;
  logic [31:0] rd;
  logic err;
  int nMismatch, testsRun;

  debug_external_interface i_dut (
    .clk_sys(clk_sys), .rst_b(rst_b), .apbReq(req), .apbRsp(rsp),
    .external_halt_request(haltPin), .halt_acknowledge(haltAck),
    .halt_accepted(haltAccepted), .restart_request(restartPin),
    .restart_acknowledge(restartAck), .keep_power_request(keepPower),
    .rom_table_base(ROM_BASE), .rom_table_base_valid(1'b1),
    .self_offset(SELF_OFS), .self_offset_valid(1'b0),
    .invasive_enable(invEn), .noninvasive_enable(noninvEn),
    .coreQuiesced(coreQuiesced), .corePrivileged(corePrivileged),
    .haltCore(haltCore), .coreInDebug(coreInDebug), .dcacheForceWriteThrough(forceWt),
    .dcacheLinefillInhibit(lfInhibit), .icacheMaintPermit(icachePermit),
    .noninvasivePermitted(nonInvPermitted), .accessFromDebugger(fromDbg)
  );

  debug_host_model i_host (
    .clk_sys(clk_sys), .rst_b(rst_b), .doHalt(doHalt), .cancelHalt(cancelHalt),
    .doRestart(doRestart),
    .haltAck(haltAck), .restartAck(restartAck), .keepPower(keepPower),
    .haltPin(haltPin), .restartPin(restartPin), .powerEmulated(powerEmulated)
  );

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // sticky capture of the short-lived halt accepted and restart acknowledge outputs
  always @(posedge clk_sys) begin
    if (clrSaw) begin
      sawAccepted <= 1'b0;
      sawRestartAck <= 1'b0;
    end else begin
      if (haltAccepted === 1'b1) sawAccepted <= 1'b1;
      if (restartAck === 1'b1) sawRestartAck <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    testsRun++;
    if (seen !== exp) begin
      nMismatch++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("mismatches %0d of %0d comparisons", nMismatch, testsRun);
    if (nMismatch == 0 && testsRun > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // one APB transfer; answer taken at the edge where pready is high
  task automatic apb(input logic wr, input logic [11:0] off, input logic [31:0] wd,
      input logic src);
    int i;
    @(negedge clk_sys);
    req.psel = 1'b1;
    req.penable = 1'b0;
    req.pwrite = wr;
    req.paddr = off[11:2];
    req.pwdata = wd;
    req.srcFlag = src;
    @(negedge clk_sys);
    req.penable = 1'b1;
    for (i = 0; i < 8; i++) begin
      @(posedge clk_sys);
      if (rsp.pready === 1'b1) break;
    end
    rd = rsp.prdata;
    err = rsp.pslverr;
    check(i, 1);
    @(negedge clk_sys);
    req.psel = 1'b0;
    req.penable = 1'b0;
  endtask

  task automatic rd_chk(input logic [11:0] off, input logic [31:0] mask,
      input logic [31:0] exp);
    apb(1'b0, off, 32'h0, 1'b1);
    check({31'h0, err}, 32'h0);
    check(rd & mask, exp);
  endtask

  task automatic pulse_halt();
    @(negedge clk_sys);
    doHalt = 1'b1;
    @(negedge clk_sys);
    doHalt = 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    req = '0;
    rst_b = 1'b0;
    invEn = 1'b1;
    noninvEn = 1'b1;
    coreQuiesced = 1'b1;
    corePrivileged = 1'b0;
    doHalt = 1'b0;
    cancelHalt = 1'b0;
    doRestart = 1'b0;
    clrSaw = 1'b1;
    nMismatch = 0;
    testsRun = 0;
    repeat (20) @(negedge clk_sys);
    rst_b = 1'b1;
    clrSaw = 1'b0;
    repeat (3) @(negedge clk_sys);
    // configuration readback, read-only places ignore writes
    rd_chk(OFF_ROM_ADDRESS, 32'hFFFF_FFFF, {ROM_BASE, 11'h000, 1'b1});
    apb(1'b1, OFF_ROM_ADDRESS, 32'h0000_0000, 1'b0);
    check({31'h0, fromDbg}, 32'h0);
    rd_chk(OFF_ROM_ADDRESS, 32'hFFFF_FFFF, {ROM_BASE, 11'h000, 1'b1});
    check({31'h0, fromDbg}, 32'h1);
    rd_chk(OFF_SELF_ADDRESS, 32'hFFFF_FFFF, {SELF_OFS, 12'h000});
    rd_chk(OFF_STATUS, 32'h0003_C403, 32'h0003_0002);
    rd_chk(OFF_AUTH_STATUS, 32'h0000_000F, 32'h0000_000F);
    // unmapped place
    apb(1'b0, 12'h004, 32'h0, 1'b0);
    check({31'h0, err}, 32'h1);
    check(rd, 32'h0);
    // keep-power
    apb(1'b1, OFF_POWER_CONTROL, 32'h0000_0001, 1'b1);
    check({31'h0, keepPower}, 32'h1);
    check({31'h0, powerEmulated}, 32'h1);
    rd_chk(OFF_POWER_CONTROL, 32'h0000_0001, 32'h0000_0001);
    apb(1'b1, OFF_POWER_CONTROL, 32'h0000_0000, 1'b1);
    check({31'h0, keepPower}, 32'h0);
    // halt through the pin
    apb(1'b1, OFF_CACHE_CONTROL, 32'h0000_0000, 1'b1);
    check({31'h0, forceWt}, 32'h0);
    pulse_halt();
    for (int k = 0; k < 20 && haltAck !== 1'b1; k++) @(negedge clk_sys);
    check({31'h0, haltAck}, 32'h1);
    check({31'h0, sawAccepted}, 32'h1);
    check({31'h0, forceWt}, 32'h1);
    check({31'h0, icachePermit}, 32'h1);
    check({31'h0, lfInhibit}, 32'h1);
    check({31'h0, coreInDebug}, 32'h1);
    rd_chk(OFF_STATUS, 32'h0000_003D, 32'h0000_0011);
    apb(1'b1, OFF_CACHE_CONTROL, 32'h0000_0004, 1'b1);
    check({31'h0, forceWt}, 32'h0);
    // restart through the pin
    @(negedge clk_sys);
    doRestart = 1'b1;
    @(negedge clk_sys);
    doRestart = 1'b0;
    for (int k = 0; k < 30 && haltAck !== 1'b0; k++) @(negedge clk_sys);
    check({31'h0, sawRestartAck}, 32'h1);
    check({31'h0, haltAck}, 32'h0);
    check({31'h0, haltCore}, 32'h0);
    check({31'h0, coreInDebug}, 32'h0);
    rd_chk(OFF_STATUS, 32'h0000_0003, 32'h0000_0002);
    // forced acknowledge
    apb(1'b1, OFF_STATUS, 32'h0000_0400, 1'b1);
    check({31'h0, haltAck}, 32'h1);
    apb(1'b1, OFF_STATUS, 32'h0000_0000, 1'b1);
    check({31'h0, haltAck}, 32'h0);
    // invasive enable low masks halt enables and refuses halts
    apb(1'b1, OFF_STATUS, 32'h0000_C000, 1'b1);
    rd_chk(OFF_STATUS, 32'h0000_C000, 32'h0000_C000);
    invEn = 1'b0;
    repeat (4) @(negedge clk_sys);
    rd_chk(OFF_STATUS, 32'h0003_C000, 32'h0002_0000);
    rd_chk(OFF_AUTH_STATUS, 32'h0000_000F, 32'h0000_000E);
    check({31'h0, nonInvPermitted}, 32'h1);
    clrSaw = 1'b1;
    @(negedge clk_sys);
    clrSaw = 1'b0;
    pulse_halt();
    apb(1'b1, OFF_RUN_CONTROL, 32'h0000_0001, 1'b1);
    repeat (6) @(negedge clk_sys);
    check({31'h0, haltCore}, 32'h0);
    check({31'h0, sawAccepted}, 32'h0);
    cancelHalt = 1'b1;
    @(negedge clk_sys);
    cancelHalt = 1'b0;
    noninvEn = 1'b0;
    repeat (4) @(negedge clk_sys);
    check({31'h0, nonInvPermitted}, 32'h0);
    invEn = 1'b1;
    repeat (4) @(negedge clk_sys);
    check({31'h0, nonInvPermitted}, 32'h1);
    // halt and restart through the run control register
    apb(1'b1, OFF_RUN_CONTROL, 32'h0000_0001, 1'b1);
    repeat (4) @(negedge clk_sys);
    check({31'h0, haltAck}, 32'h1);
    rd_chk(OFF_STATUS, 32'h0000_003F, 32'h0000_0003);
    apb(1'b1, OFF_RUN_CONTROL, 32'h0000_0002, 1'b1);
    check({31'h0, haltAck}, 32'h0);
    check({31'h0, haltCore}, 32'h0);
    rd_chk(OFF_STATUS, 32'h0000_0003, 32'h0000_0002);
    end_of_test();
  end

  // watchdog
  initial begin
    repeat (20000) @(posedge clk_sys);
    nMismatch++;
    end_of_test();
  end
endmodule
